// *** common/svs_pkg.sv ***
// Purpose: shared constants of the supply voltage statistics readout
// Assumes: 32-bit avalon word per register, byte address = 4 * index
// Notes:   indices 0x28 and 0x29 hold the control and mode registers
package svs_pkg;
  // ==========================================================
  // widths
  localparam int RES_W   = 12;
  localparam int BYTE_W  = 8;
  localparam int NIB_W   = RES_W - BYTE_W;
  localparam int IDX_W   = 7;
  localparam int ADDR_W  = IDX_W + 2;
  localparam int DATA_W  = 32;
  localparam int FRAC_W  = 15;
  localparam int NUM_RES = 3;
  // ==========================================================
  // register indices
  localparam logic [IDX_W-1:0] IDX_AVG_UP = 7'h1b;
  localparam logic [IDX_W-1:0] IDX_AVG_LO = 7'h1c;
  localparam logic [IDX_W-1:0] IDX_MIN_UP = 7'h1d;
  localparam logic [IDX_W-1:0] IDX_MIN_LO = 7'h1e;
  localparam logic [IDX_W-1:0] IDX_MAX_UP = 7'h1f;
  localparam logic [IDX_W-1:0] IDX_MAX_LO = 7'h20;
  localparam logic [IDX_W-1:0] IDX_MCTRL  = 7'h28;
  localparam logic [IDX_W-1:0] IDX_MODE   = 7'h29;
  // ==========================================================
  // fields and reset values
  localparam int TAU_W    = 4;
  localparam int TAU_LSB  = 0;
  localparam int CLR_BIT  = 7;
  localparam int MODE_BIT = 0;
  localparam logic [TAU_W-1:0]  TAU_RST    = 4'h4;
  localparam logic [BYTE_W-1:0] REG_RST    = 8'h00;
  localparam logic [RES_W-1:0]  RES_ZERO   = 12'h000;
  localparam logic [RES_W-1:0]  RES_FULL   = 12'hfff;
  localparam logic [1:0]        ADDR_ALIGN = 2'h0;
  // ==========================================================
  // result selectors
  localparam logic [1:0] SEL_AVG  = 2'h0;
  localparam logic [1:0] SEL_MIN  = 2'h1;
  localparam logic [1:0] SEL_MAX  = 2'h2;
  localparam logic [1:0] SEL_NONE = 2'h3;
endpackage

// *** common/svs_meas_if.sv ***
// Purpose: selected supply sample and filter settings to the trackers
// Assumes: all signals on the block clock
// Notes:   driven by the top, read by the average and extreme trackers
`timescale 1ns/1ps
interface svs_meas_if
  import svs_pkg::*;
();
  logic [RES_W-1:0] sample;
  logic             valid;
  logic             clear;
  logic [TAU_W-1:0] tau;
  modport src  (output sample, output valid, output clear, output tau);
  modport sink (input sample, input valid, input clear, input tau);
endinterface

// *** design/svs_iir.sv ***
// Purpose: iir low-pass average of the selected supply sample
// Assumes: tau gives a right shift of the error term
// Notes:   first sample after a clear loads the average directly
`timescale 1ns/1ps
module svs_iir
  import svs_pkg::*;
#(
  parameter int F = FRAC_W
) (
  input  wire logic             clk,
  input  wire logic             rst,
  svs_meas_if.sink              m,
  output logic      [RES_W-1:0] avg
);
  logic        [RES_W+F-1:0] acc_ff;
  logic                      seen_ff;
  logic signed [RES_W+F:0]   diff;
  logic signed [RES_W+F:0]   step;

  assign diff = $signed({1'b0, m.sample, {F{1'b0}}}) - $signed({1'b0, acc_ff});
  assign step = diff >>> m.tau;
  assign avg  = acc_ff[RES_W+F-1:F];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_ff  <= '0;
      seen_ff <= 1'b0;
    end else if (m.clear) begin
      acc_ff  <= '0;
      seen_ff <= 1'b0;
    end else if (m.valid) begin
      seen_ff <= 1'b1;
      if (!seen_ff) begin
        acc_ff <= {m.sample, {F{1'b0}}};
      end else begin
        acc_ff <= acc_ff + step[RES_W+F-1:0];
      end
    end
  end
endmodule

// *** design/svs_extreme.sv ***
// Purpose: minimum or maximum of the selected supply sample
// Assumes: IS_MAX picks the maximum, otherwise the minimum
// Notes:   reads zero until the first sample after a clear
`timescale 1ns/1ps
module svs_extreme
  import svs_pkg::*;
#(
  parameter bit IS_MAX = 1'b0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  svs_meas_if.sink              m,
  output logic      [RES_W-1:0] ext
);
  localparam logic [RES_W-1:0] START = IS_MAX ? RES_ZERO : RES_FULL;
  logic [RES_W-1:0] ext_ff;
  logic             seen_ff;
  logic             better;

  assign better = IS_MAX ? (m.sample > ext_ff) : (m.sample < ext_ff);
  assign ext    = seen_ff ? ext_ff : RES_ZERO;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_ff  <= START;
      seen_ff <= 1'b0;
    end else if (m.clear) begin
      ext_ff  <= START;
      seen_ff <= 1'b0;
    end else if (m.valid) begin
      seen_ff <= 1'b1;
      if (better || !seen_ff) begin
        ext_ff <= m.sample;
      end
    end
  end
endmodule

// *** design/svs_readout.sv ***
// Purpose: supply voltage average, minimum and maximum result registers
// Assumes: avalon-mm slave with waitrequest, samples on the same clock
// Notes:   each request answers with waitrequest low on its second edge
`timescale 1ns/1ps
module svs_readout
  import svs_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [DATA_W-1:0] avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic [RES_W-1:0]  primary_battery_pin_sample,
  input  wire logic [RES_W-1:0]  secondary_supply_pin_sample,
  input  wire logic              sample_valid,
  output logic                   supply_present_mode
);
  // ==========================================================
  // decoding helpers
  function automatic logic [1:0] res_sel(input logic [IDX_W-1:0] i);
    case (i)
      IDX_AVG_UP, IDX_AVG_LO: res_sel = SEL_AVG;
      IDX_MIN_UP, IDX_MIN_LO: res_sel = SEL_MIN;
      IDX_MAX_UP, IDX_MAX_LO: res_sel = SEL_MAX;
      default:                res_sel = SEL_NONE;
    endcase
  endfunction

  function automatic logic is_upper(input logic [IDX_W-1:0] i);
    is_upper = (i == IDX_AVG_UP) || (i == IDX_MIN_UP) || (i == IDX_MAX_UP);
  endfunction

  // ==========================================================
  // bus handshake
  logic [DATA_W-1:0] readdata_ff;
  logic [DATA_W-1:0] nxt_readdata;
  logic              wait_ff;
  logic              req;
  logic              take;
  logic              done;
  logic              aligned;
  logic [IDX_W-1:0]  idx;
  logic [1:0]        addr_sel;

  assign req      = avs_read || avs_write;
  assign take     = req && wait_ff;
  assign done     = req && !wait_ff;
  assign idx      = avs_address[ADDR_W-1:2];
  assign aligned  = (avs_address[1:0] == ADDR_ALIGN);
  assign addr_sel = (req && aligned) ? res_sel(idx) : SEL_NONE;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_ff <= 1'b1;
    end else if (take) begin
      wait_ff <= 1'b0;
    end else begin
      wait_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata_ff <= '0;
    end else if (take) begin
      readdata_ff <= nxt_readdata;
    end
  end

  assign avs_readdata    = readdata_ff;
  assign avs_waitrequest = wait_ff;

  // ==========================================================
  // control registers
  logic [TAU_W-1:0] tau_ff;
  logic             mode_ff;
  logic             clear_ff;
  logic             wr_ok;

  assign wr_ok = done && avs_write && aligned && avs_byteenable[0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tau_ff <= TAU_RST;
    end else if (wr_ok && (idx == IDX_MCTRL)) begin
      tau_ff <= avs_writedata[TAU_LSB +: TAU_W];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clear_ff <= 1'b0;
    end else begin
      clear_ff <= wr_ok && (idx == IDX_MCTRL) && avs_writedata[CLR_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_ff <= 1'b0;
    end else if (wr_ok && (idx == IDX_MODE)) begin
      mode_ff <= avs_writedata[MODE_BIT];
    end
  end

  assign supply_present_mode = mode_ff;

  // ==========================================================
  // supply selection into the trackers
  svs_meas_if meas ();

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meas.sample <= RES_ZERO;
      meas.valid  <= 1'b0;
    end else begin
      meas.valid  <= sample_valid;
      meas.sample <= mode_ff ? secondary_supply_pin_sample
                             : primary_battery_pin_sample;
    end
  end

  assign meas.clear = clear_ff;
  assign meas.tau   = tau_ff;

  logic [RES_W-1:0] live [NUM_RES];

  svs_iir #(
    .F   (FRAC_W)
  ) u_avg (
    .clk (clk),
    .rst (rst),
    .m   (meas.sink),
    .avg (live[SEL_AVG])
  );

  svs_extreme #(
    .IS_MAX (1'b0)
  ) u_min (
    .clk    (clk),
    .rst    (rst),
    .m      (meas.sink),
    .ext    (live[SEL_MIN])
  );

  svs_extreme #(
    .IS_MAX (1'b1)
  ) u_max (
    .clk    (clk),
    .rst    (rst),
    .m      (meas.sink),
    .ext    (live[SEL_MAX])
  );

  // ==========================================================
  // visible results and shadows
  logic [RES_W-1:0]  vis_ff    [NUM_RES];
  logic [BYTE_W-1:0] shadow_ff [NUM_RES];

  for (genvar g = 0; g < NUM_RES; g++) begin : g_res
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        vis_ff[g] <= RES_ZERO;
      end else if (addr_sel != 2'(g)) begin
        vis_ff[g] <= live[g];
      end
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        shadow_ff[g] <= REG_RST;
      end else if (done && avs_read && is_upper(idx) && addr_sel == 2'(g)) begin
        shadow_ff[g] <= vis_ff[g][BYTE_W-1:0];
      end
    end
  end

  // ==========================================================
  // read mux
  always_comb begin
    nxt_readdata = '0;
    if (aligned && avs_read) begin
      case (idx)
        IDX_AVG_UP: nxt_readdata[NIB_W-1:0] = vis_ff[SEL_AVG][RES_W-1:BYTE_W];
        IDX_MIN_UP: nxt_readdata[NIB_W-1:0] = vis_ff[SEL_MIN][RES_W-1:BYTE_W];
        IDX_MAX_UP: nxt_readdata[NIB_W-1:0] = vis_ff[SEL_MAX][RES_W-1:BYTE_W];
        IDX_AVG_LO: nxt_readdata[BYTE_W-1:0] = shadow_ff[SEL_AVG];
        IDX_MIN_LO: nxt_readdata[BYTE_W-1:0] = shadow_ff[SEL_MIN];
        IDX_MAX_LO: nxt_readdata[BYTE_W-1:0] = shadow_ff[SEL_MAX];
        IDX_MCTRL:  nxt_readdata[TAU_LSB +: TAU_W] = tau_ff;
        IDX_MODE:   nxt_readdata[MODE_BIT] = mode_ff;
        default:    nxt_readdata = '0;
      endcase
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_avg_track;
    (addr_sel != SEL_AVG) |=> vis_ff[SEL_AVG] == $past(live[SEL_AVG]);
  endproperty
  a_avg_track: assert property (p_avg_track) else $error("average not refreshed");

  property p_tau_write;
    (wr_ok && idx == IDX_MCTRL) |=> meas.tau == $past(avs_writedata[TAU_LSB +: TAU_W]);
  endproperty
  a_tau_write: assert property (p_tau_write) else $error("tau not taken");

  property p_pin_sel;
    (mode_ff && !(wr_ok && idx == IDX_MODE))
      |=> meas.sample == $past(secondary_supply_pin_sample);
  endproperty
  a_pin_sel: assert property (p_pin_sel) else $error("wrong supply pin");

  property p_hold;
    (addr_sel == SEL_MIN) |=> vis_ff[SEL_MIN] == $past(vis_ff[SEL_MIN]);
  endproperty
  a_hold: assert property (p_hold) else $error("held result changed");

  property p_shadow_cap;
    (done && avs_read && aligned && idx == IDX_MAX_UP)
      |=> shadow_ff[SEL_MAX] == $past(vis_ff[SEL_MAX][BYTE_W-1:0]);
  endproperty
  a_shadow_cap: assert property (p_shadow_cap) else $error("shadow not captured");

  property p_lo_read;
    (take && avs_read && aligned && idx == IDX_AVG_LO)
      |=> !avs_waitrequest && avs_readdata == {24'h0, $past(shadow_ff[SEL_AVG])};
  endproperty
  a_lo_read: assert property (p_lo_read) else $error("lower read not shadow");

  property p_min_up;
    (take && avs_read && aligned && idx == IDX_MIN_UP)
      |=> avs_readdata == {28'h0, $past(vis_ff[SEL_MIN][RES_W-1:BYTE_W])};
  endproperty
  a_min_up: assert property (p_min_up) else $error("min upper wrong");

  property p_min_lo;
    (take && avs_read && aligned && idx == IDX_MIN_LO)
      |=> avs_readdata[BYTE_W-1:0] == $past(shadow_ff[SEL_MIN]);
  endproperty
  a_min_lo: assert property (p_min_lo) else $error("min lower wrong");

  property p_max_grow;
    !meas.clear |=> live[SEL_MAX] >= $past(live[SEL_MAX]);
  endproperty
  a_max_grow: assert property (p_max_grow) else $error("max fell");

  property p_clear;
    meas.clear |=> live[SEL_MIN] == RES_ZERO && live[SEL_MAX] == RES_ZERO
               && live[SEL_AVG] == RES_ZERO;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not restart");

  property p_handshake;
    take |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_handshake: assert property (p_handshake) else $error("bad waitrequest");

  property p_hold_avg;
    (addr_sel == SEL_AVG) |=> vis_ff[SEL_AVG] == $past(vis_ff[SEL_AVG]);
  endproperty
  a_hold_avg: assert property (p_hold_avg) else $error("held average changed");

  property p_hold_max;
    (addr_sel == SEL_MAX) |=> vis_ff[SEL_MAX] == $past(vis_ff[SEL_MAX]);
  endproperty
  a_hold_max: assert property (p_hold_max) else $error("held maximum changed");

  property p_shadow_avg;
    (done && avs_read && aligned && idx == IDX_AVG_UP)
      |=> shadow_ff[SEL_AVG] == $past(vis_ff[SEL_AVG][BYTE_W-1:0]);
  endproperty
  a_shadow_avg: assert property (p_shadow_avg) else $error("avg shadow not captured");

  property p_shadow_min;
    (done && avs_read && aligned && idx == IDX_MIN_UP)
      |=> shadow_ff[SEL_MIN] == $past(vis_ff[SEL_MIN][BYTE_W-1:0]);
  endproperty
  a_shadow_min: assert property (p_shadow_min) else $error("min shadow not captured");

  property p_shadow_keep;
    !(done && avs_read && is_upper(idx) && addr_sel == SEL_MIN)
      |=> $stable(shadow_ff[SEL_MIN]);
  endproperty
  a_shadow_keep: assert property (p_shadow_keep) else $error("min shadow moved");

  property p_max_lo;
    (take && avs_read && aligned && idx == IDX_MAX_LO)
      |=> avs_readdata == {24'h0, $past(shadow_ff[SEL_MAX])};
  endproperty
  a_max_lo: assert property (p_max_lo) else $error("max lower wrong");

  property p_avg_up;
    (take && avs_read && aligned && idx == IDX_AVG_UP)
      |=> avs_readdata == {28'h0, $past(vis_ff[SEL_AVG][RES_W-1:BYTE_W])};
  endproperty
  a_avg_up: assert property (p_avg_up) else $error("avg upper wrong");

  property p_min_bound;
    (meas.valid && !meas.clear) |=> live[SEL_MIN] <= $past(meas.sample);
  endproperty
  a_min_bound: assert property (p_min_bound) else $error("min above sample");

  property p_max_bound;
    (meas.valid && !meas.clear) |=> live[SEL_MAX] >= $past(meas.sample);
  endproperty
  a_max_bound: assert property (p_max_bound) else $error("max below sample");

  property p_mode_write;
    (wr_ok && idx == IDX_MODE) |=> supply_present_mode == $past(avs_writedata[MODE_BIT]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode not taken");

  c_up_read:  cover property (done && avs_read && is_upper(idx));
  c_max_lo:   cover property (done && avs_read && idx == IDX_MAX_LO);
  c_lo_read:  cover property (done && avs_read && idx == IDX_MIN_LO);
  c_clear:    cover property (meas.clear);
  c_mode_sec: cover property (mode_ff && meas.valid);
endmodule

// *** tb/tb_top.sv ***
// Purpose: self-checking bench for the supply voltage statistics readout
// Assumes: avalon-mm master on one 125 MHz clock, samples driven by the bench
// Notes:   each scenario is its own task and judges its own reads
`timescale 1ns/1ps
module tb_top
  import svs_pkg::*;
;
  // ==========================================================
  // signals
  logic              clk;
  logic              rst;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [DATA_W-1:0] avs_writedata;
  logic [3:0]        avs_byteenable;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic [RES_W-1:0]  pri_smp;
  logic [RES_W-1:0]  sec_smp;
  logic              smp_valid;
  logic              mode_out;
  int                n_errors;
  int                total_checks;
  int                cycles;

  svs_readout dut (
    .clk                         (clk),
    .rst                         (rst),
    .avs_address                 (avs_address),
    .avs_read                    (avs_read),
    .avs_write                   (avs_write),
    .avs_writedata               (avs_writedata),
    .avs_byteenable              (avs_byteenable),
    .avs_readdata                (avs_readdata),
    .avs_waitrequest             (avs_waitrequest),
    .primary_battery_pin_sample  (pri_smp),
    .secondary_supply_pin_sample (sec_smp),
    .sample_valid                (smp_valid),
    .supply_present_mode         (mode_out)
  );

  always #4 clk = ~clk;

  // ==========================================================
  // closing and timeout
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      $display("MISMATCH t=%0t bench timed out", $time);
      wrap_up();
    end
  end

  // ==========================================================
  // bus and compare helpers
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
                     input string what);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic is_wr, input logic [IDX_W-1:0] idx, input logic [7:0] wd,
                     input logic [3:0] be, output logic [DATA_W-1:0] rdata);
    logic wt;
    avs_address    <= {idx, ADDR_ALIGN};
    avs_read       <= !is_wr;
    avs_write      <= is_wr;
    avs_writedata  <= {24'h000000, wd};
    avs_byteenable <= be;
    wt = 1'b1;
    rdata = '0;
    // values read here are those sampled by this rising edge
    while (wt) begin
      @(posedge clk);
      wt = avs_waitrequest;
      rdata = avs_readdata;
    end
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [IDX_W-1:0] idx, input logic [7:0] exp, input string what);
    logic [DATA_W-1:0] r;
    bus(1'b0, idx, 8'h00, 4'h1, r);
    chk(r, {24'h000000, exp}, what);
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d, input logic [3:0] be);
    logic [DATA_W-1:0] r;
    bus(1'b1, idx, d, be, r);
  endtask

  // upper nibble then lower byte of one result
  task automatic rdres(input logic [IDX_W-1:0] up, input logic [RES_W-1:0] exp,
                       input string what);
    rd(up, {4'h0, exp[11:8]}, what);
    rd(up + 7'h01, exp[7:0], what);
  endtask

  // software conversion: ((upper << 8) + lower) * k / 100 millivolts
  task automatic mv(input logic [IDX_W-1:0] up, input int k, input int exp,
                    input string what);
    logic [DATA_W-1:0] hi;
    logic [DATA_W-1:0] lo;
    bus(1'b0, up, 8'h00, 4'h1, hi);
    bus(1'b0, up + 7'h01, 8'h00, 4'h1, lo);
    chk(((hi << 8) + lo) * k / 100, exp, what);
  endtask

  task automatic smp(input logic [RES_W-1:0] p, input logic [RES_W-1:0] s);
    pri_smp   <= p;
    sec_smp   <= s;
    smp_valid <= 1'b1;
    @(posedge clk);
    smp_valid <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    rdres(IDX_AVG_UP, RES_ZERO, "avg reset");
    rdres(IDX_MIN_UP, RES_ZERO, "min reset");
    rdres(IDX_MAX_UP, RES_ZERO, "max reset");
    rd(IDX_MCTRL, {4'h0, TAU_RST}, "tau reset");
    rd(IDX_MODE, 8'h00, "mode reset");
    rd(7'h30, 8'h00, "unmapped read");
    chk({31'h0, mode_out}, 32'h0, "mode pin reset");
  endtask

  task automatic t_minmax();
    wr(IDX_MCTRL, 8'h84, 4'h1);
    rdres(IDX_MIN_UP, RES_ZERO, "min after clear");
    smp(12'h123, 12'heee);
    smp(12'h456, 12'h001);
    smp(12'h0ab, 12'h777);
    rdres(IDX_MIN_UP, 12'h0ab, "min primary");
    mv(IDX_MIN_UP, 149, 254, "min millivolt primary");
    rdres(IDX_MAX_UP, 12'h456, "max primary");
    wr(IDX_MIN_LO, 8'hff, 4'h1);
    wr(IDX_MIN_UP, 8'h0f, 4'h1);
    rdres(IDX_MIN_UP, 12'h0ab, "min read-only");
  endtask

  task automatic t_avg();
    wr(IDX_MCTRL, 8'h80, 4'h1);
    smp(12'h100, 12'h000);
    rdres(IDX_AVG_UP, 12'h100, "avg first load");
    wr(IDX_MCTRL, 8'h01, 4'h1);
    rd(IDX_MCTRL, 8'h01, "tau written");
    smp(12'h300, 12'h000);
    rdres(IDX_AVG_UP, 12'h200, "avg tau 1");
    wr(IDX_MCTRL, 8'h02, 4'h1);
    smp(12'h600, 12'h000);
    rdres(IDX_AVG_UP, 12'h300, "avg tau 2");
  endtask

  task automatic t_mode();
    wr(IDX_MODE, 8'h01, 4'h0);
    chk({31'h0, mode_out}, 32'h0, "write without lane 0");
    wr(IDX_MODE, 8'h01, 4'h1);
    chk({31'h0, mode_out}, 32'h1, "mode pin set");
    rd(IDX_MODE, 8'h01, "mode read");
    wr(IDX_MCTRL, 8'h80, 4'h1);
    smp(12'h111, 12'h999);
    rdres(IDX_MIN_UP, 12'h999, "min secondary");
    mv(IDX_MIN_UP, 101, 2481, "min millivolt secondary");
    rdres(IDX_MAX_UP, 12'h999, "max secondary");
    rdres(IDX_AVG_UP, 12'h999, "avg secondary");
    wr(IDX_MODE, 8'h00, 4'h1);
  endtask

  task automatic t_shadow();
    wr(IDX_MCTRL, 8'h80, 4'h1);
    smp(12'h2a5, 12'h000);
    rd(IDX_MAX_UP, 8'h02, "max upper");
    smp(12'h3c7, 12'h000);
    rd(IDX_MAX_LO, 8'ha5, "max lower from shadow");
    rdres(IDX_MAX_UP, 12'h3c7, "max after update");
    rd(IDX_MIN_LO, 8'h99, "min lower stale shadow");
    rdres(IDX_MIN_UP, 12'h2a5, "min pair");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    clk            = 1'b0;
    rst            = 1'b1;
    avs_address    = '0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = '0;
    avs_byteenable = 4'h0;
    pri_smp        = '0;
    sec_smp        = '0;
    smp_valid      = 1'b0;
    n_errors       = 0;
    total_checks   = 0;
    cycles         = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_minmax();
    t_avg();
    t_mode();
    t_shadow();
    wrap_up();
  end
endmodule
